/* File: include/lbt_regs.svh */
// Structural sizes and reset values of the logic block tile.
`ifndef LBT_REGS_SVH
`define LBT_REGS_SVH
`define LBT_CELLS 4
`define LBT_SLICES 2
`define LBT_CPS 2
`define LBT_LUT_AW 4
`define LBT_LUT_DEPTH 16
`define LBT_DRIVERS 2
`define LBT_FEEDS 4
`define LBT_OUT_RST 1'b0
`define LBT_PREV_RST 1'b0
`endif

/* File: include/lbt_pkg.sv */
// Types shared by the logic block tile and its slice storage module.
`include "lbt_regs.svh"
package lbt_pkg;
  typedef enum logic [2:0] {
    LBT_RM_LOGIC = 3'b000,
    LBT_RM_16X1 = 3'b001,
    LBT_RM_16X2 = 3'b010,
    LBT_RM_32X1 = 3'b011,
    LBT_RM_DUAL = 3'b100,
    LBT_RM_SHIFT = 3'b101
  } lbt_ram_mode_e;

  typedef struct packed {
    lbt_ram_mode_e mode;
    logic latch;
    logic async_force;
    logic inv_clk;
    logic inv_ce;
    logic inv_init;
    logic inv_opp;
    logic [`LBT_CPS-1:0] init_val;
    logic [`LBT_CPS-1:0] d_bypass;
    logic [`LBT_CPS-1:0] mult_and;
    logic [`LBT_CPS-1:0][`LBT_LUT_DEPTH-1:0] lut_init;
  } lbt_slice_cfg_s;

  typedef struct packed {
    logic clk_in;
    logic ce;
    logic init_force;
    logic opposite_force;
    logic we;
    logic f5_sel;
    logic cin;
    logic [`LBT_CPS-1:0] bypass;
    logic [`LBT_CPS-1:0][`LBT_LUT_AW-1:0] addr;
  } lbt_slice_ctl_s;

  typedef struct packed {
    logic clk_prev;
    logic [`LBT_CPS-1:0] q;
  } lbt_store_state_s;

  typedef struct packed {
    logic [`LBT_CELLS-1:0][`LBT_LUT_DEPTH-1:0] lookup_function_gen;
    logic [`LBT_CELLS-1:0] gen_out;
    logic [`LBT_CELLS-1:0] sum;
    logic [`LBT_SLICES-1:0] five;
    logic six;
    logic [`LBT_SLICES-1:0] cout;
    logic [`LBT_FEEDS-1:0] feed;
    logic [`LBT_DRIVERS-1:0] bus_o;
    logic [`LBT_DRIVERS-1:0] bus_oe;
  } lbt_tile_state_s;
endpackage

/* File: src/lbt_slice_store.sv */
// Storage element pair of one slice with shared, invertible clock, enable and force controls.
`timescale 1ns/1ps
`default_nettype none
`include "lbt_regs.svh"
module lbt_slice_store
(
  input wire logic clk,
  input wire logic rst_n,
  input wire lbt_pkg::lbt_slice_cfg_s cfg,
  input wire lbt_pkg::lbt_slice_ctl_s ctl,
  input wire logic [`LBT_CPS-1:0] d,
  output logic [`LBT_CPS-1:0] q,
  output logic act_edge
);
  lbt_pkg::lbt_store_state_s s;
  lbt_pkg::lbt_store_state_s next_s;
  logic ck;
  logic cen;
  logic sr;
  logic by;

  // Each control has its own inversion but both elements see the same result.
  assign ck = ctl.clk_in ^ cfg.inv_clk;
  assign cen = ctl.ce ^ cfg.inv_ce;
  assign sr = ctl.init_force ^ cfg.inv_init;
  assign by = ctl.opposite_force ^ cfg.inv_opp;
  // The slice clock is a fabric level, so its active edge is found by comparison.
  assign act_edge = ck & ~s.clk_prev;
  assign q = s.q;

  always_comb
  begin
    next_s = s;
    next_s.clk_prev = ck;
    for (int k = 0; k < `LBT_CPS; k++)
    begin
      if (cfg.async_force && sr)
        next_s.q[k] = cfg.init_val[k];
      else if (cfg.async_force && by)
        next_s.q[k] = ~cfg.init_val[k];
      else if (cfg.latch ? ck : act_edge)
      begin
        if (sr)
          next_s.q[k] = cfg.init_val[k];
        else if (by)
          next_s.q[k] = ~cfg.init_val[k];
        else if (cen)
          next_s.q[k] = d[k];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s.clk_prev <= `LBT_PREV_RST;
      s.q <= cfg.init_val;
    end
    else
    begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_async_init: assert property (cfg.async_force && sr |=> q == $past(cfg.init_val))
    else $error("async init force did not load init value");
  a_opp_value: assert property (!cfg.async_force && !cfg.latch && act_edge && !sr && by
    |=> q == ~$past(cfg.init_val))
    else $error("opposite force did not load complement");
  a_ff_hold: assert property (!cfg.latch && !cfg.async_force && !act_edge |=> $stable(q))
    else $error("flip-flop changed without active edge");
  a_shared_load: assert property (!cfg.latch && !cfg.async_force && act_edge && cen && !sr && !by
    |=> q == $past(d))
    else $error("shared clock edge did not load both elements");
  a_async_opp: assert property (cfg.async_force && !sr && by
    |=> q == ~$past(cfg.init_val))
    else $error("async opposite force did not load complement");
  a_latch_follow: assert property (cfg.latch && !cfg.async_force && ck && !sr && !by && cen
    |=> q == $past(d))
    else $error("open latch did not follow D");
  c_async_hit: cover property (cfg.async_force && by && !ck);
endmodule
`default_nettype wire

/* File: src/lbt_tile.sv */
// Logic block tile: two slices of lookup generators, carry chains, wide muxes and bus drivers.
`timescale 1ns/1ps
`default_nettype none
`include "lbt_regs.svh"
module lbt_tile
(
  input wire logic clk,
  input wire logic rst_n,
  input wire lbt_pkg::lbt_slice_cfg_s [`LBT_SLICES-1:0] cfg,
  input wire lbt_pkg::lbt_slice_ctl_s [`LBT_SLICES-1:0] ctl,
  input wire logic six_sel,
  input wire logic [`LBT_FEEDS-1:0] feed_in,
  input wire logic [`LBT_DRIVERS-1:0] drv_data,
  input wire logic [`LBT_DRIVERS-1:0] drv_en,
  output logic [`LBT_CELLS-1:0] gen_out,
  output logic [`LBT_CELLS-1:0] q,
  output logic [`LBT_CELLS-1:0] sum_out,
  output logic [`LBT_SLICES-1:0] five_out,
  output logic six_out,
  output logic [`LBT_SLICES-1:0] cout,
  output logic [`LBT_FEEDS-1:0] feed_out,
  output logic [`LBT_DRIVERS-1:0] bus_o,
  output logic [`LBT_DRIVERS-1:0] bus_oe
);
  lbt_pkg::lbt_tile_state_s s;
  lbt_pkg::lbt_tile_state_s next_s;
  logic [`LBT_CELLS-1:0][`LBT_LUT_AW-1:0] raddr;
  logic [`LBT_CELLS-1:0][`LBT_LUT_AW-1:0] waddr;
  logic [`LBT_CELLS-1:0] gen;
  logic [`LBT_CELLS-1:0] wdata;
  logic [`LBT_CELLS-1:0] wr;
  logic [`LBT_CELLS-1:0] sh;
  logic [`LBT_CELLS-1:0] dsel;
  logic [`LBT_CELLS-1:0] cgen;
  logic [`LBT_CELLS-1:0] cin_c;
  logic [`LBT_CELLS-1:0] cy;
  logic [`LBT_CELLS-1:0] sm;
  logic [`LBT_SLICES-1:0] f5;
  logic [`LBT_SLICES-1:0] act_edge;
  logic six;

  genvar c;
  genvar g;

  generate
    for (c = 0; c < `LBT_CELLS; c++)
    begin : g_cell
      localparam int SL = c / `LBT_CPS;
      localparam int K = c % `LBT_CPS;
      lbt_pkg::lbt_ram_mode_e mode;
      logic shared_port;
      logic ram_mode;
      logic own_data;
      logic wsel;

      assign mode = cfg[SL].mode;
      // Wide and two-bit RAM run both generators on the first cell's address.
      assign shared_port = (mode == lbt_pkg::LBT_RM_16X2) ||
                           (mode == lbt_pkg::LBT_RM_32X1);
      assign ram_mode = (mode == lbt_pkg::LBT_RM_16X1) ||
                        (mode == lbt_pkg::LBT_RM_16X2) ||
                        (mode == lbt_pkg::LBT_RM_32X1) ||
                        (mode == lbt_pkg::LBT_RM_DUAL);
      assign own_data = (mode == lbt_pkg::LBT_RM_16X1) ||
                        (mode == lbt_pkg::LBT_RM_16X2) ||
                        (mode == lbt_pkg::LBT_RM_SHIFT);

      // The read port is a plain index, so a read follows its address at once.
      assign raddr[c] = shared_port ? ctl[SL].addr[0] : ctl[SL].addr[K];
      assign gen[c] = s.lookup_function_gen[c][raddr[c]];

      // In dual-port mode the second generator mirrors writes made through the first.
      assign waddr[c] = (mode == lbt_pkg::LBT_RM_16X1) ? ctl[SL].addr[K] :
                        ctl[SL].addr[0];
      assign wdata[c] = own_data ? ctl[SL].bypass[K] : ctl[SL].bypass[0];

      // The five-input mux select doubles as the top address bit of the 32-word RAM.
      assign wsel = (mode == lbt_pkg::LBT_RM_32X1) ?
                    (ctl[SL].f5_sel == (K == 1)) : 1'b1;
      assign wr[c] = act_edge[SL] & ctl[SL].we & wsel & ram_mode;
      assign sh[c] = act_edge[SL] & ctl[SL].we &
                     (mode == lbt_pkg::LBT_RM_SHIFT);

      // Storage D is taken from the generator or from the bypass input.
      assign dsel[c] = cfg[SL].d_bypass[K] ? ctl[SL].bypass[K] : gen[c];

      // With mult_and clear and the bypass input held low the chain is an AND of generators.
      assign cgen[c] = cfg[SL].mult_and[K] ?
                       (ctl[SL].addr[K][0] & ctl[SL].addr[K][1]) :
                       ctl[SL].bypass[K];

      if (K == 0)
      begin : g_first
        assign cin_c[c] = ctl[SL].cin;
      end
      else
      begin : g_next
        assign cin_c[c] = cy[c - 1];
      end

      // Generator output is the propagate term of the carry multiplexer.
      assign cy[c] = gen[c] ? cin_c[c] : cgen[c];
      assign sm[c] = gen[c] ^ cin_c[c];
    end

    for (g = 0; g < `LBT_SLICES; g++)
    begin : g_slice
      assign f5[g] = ctl[g].f5_sel ? gen[2 * g + 1] : gen[2 * g];

      lbt_slice_store u_store
      (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(cfg[g]),
        .ctl(ctl[g]),
        .d(dsel[2 * g + 1:2 * g]),
        .q(q[2 * g + 1:2 * g]),
        .act_edge(act_edge[g])
      );
    end
  endgenerate

  assign six = six_sel ? f5[1] : f5[0];

  always_comb
  begin
    next_s = s;
    for (int i = 0; i < `LBT_CELLS; i++)
    begin
      if (wr[i])
        next_s.lookup_function_gen[i][waddr[i]] = wdata[i];
      else if (sh[i])
        next_s.lookup_function_gen[i] = {s.lookup_function_gen[i][`LBT_LUT_DEPTH-2:0], wdata[i]};
    end
    next_s.gen_out = gen;
    next_s.sum = sm;
    next_s.five = f5;
    next_s.six = six;
    // Only the top cell of each slice leaves the tile toward the next one.
    next_s.cout = {cy[3], cy[1]};
    next_s.feed = feed_in;
    next_s.bus_o = drv_data;
    next_s.bus_oe = drv_en;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      // Lookup contents come from configuration, as a loaded bitstream would give.
      s.lookup_function_gen <= {cfg[1].lut_init, cfg[0].lut_init};
      s.gen_out <= {`LBT_CELLS{`LBT_OUT_RST}};
      s.sum <= {`LBT_CELLS{`LBT_OUT_RST}};
      s.five <= {`LBT_SLICES{`LBT_OUT_RST}};
      s.six <= `LBT_OUT_RST;
      s.cout <= {`LBT_SLICES{`LBT_OUT_RST}};
      s.feed <= {`LBT_FEEDS{`LBT_OUT_RST}};
      s.bus_o <= {`LBT_DRIVERS{`LBT_OUT_RST}};
      s.bus_oe <= {`LBT_DRIVERS{`LBT_OUT_RST}};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign gen_out = s.gen_out;
  assign sum_out = s.sum;
  assign five_out = s.five;
  assign six_out = s.six;
  assign cout = s.cout;
  assign feed_out = s.feed;
  assign bus_o = s.bus_o;
  assign bus_oe = s.bus_oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_logic_read: assert property (cfg[0].mode == lbt_pkg::LBT_RM_LOGIC
    |=> gen_out[0] == $past(s.lookup_function_gen[0][ctl[0].addr[0]]))
    else $error("generator output does not match lookup contents");

  a_ram_write: assert property (cfg[0].mode == lbt_pkg::LBT_RM_16X1 && act_edge[0] && ctl[0].we
    |=> s.lookup_function_gen[0][$past(ctl[0].addr[0])] == $past(ctl[0].bypass[0]))
    else $error("single RAM write not stored");

  a_pair_write: assert property (cfg[0].mode == lbt_pkg::LBT_RM_16X2 && act_edge[0] && ctl[0].we
    |=> s.lookup_function_gen[1][$past(ctl[0].addr[0])] == $past(ctl[0].bypass[1]))
    else $error("two-bit RAM upper bit not stored");

  a_ram_idle: assert property (cfg[0].mode != lbt_pkg::LBT_RM_LOGIC && !ctl[0].we
    |=> $stable(s.lookup_function_gen[1:0]))
    else $error("lookup contents changed without write enable");

  a_shift_step: assert property (cfg[1].mode == lbt_pkg::LBT_RM_SHIFT && act_edge[1] && ctl[1].we
    |=> s.lookup_function_gen[3] == {$past(s.lookup_function_gen[3][`LBT_LUT_DEPTH-2:0]), $past(ctl[1].bypass[1])})
    else $error("shift register did not advance by one");

  a_five_mux: assert property (1'b1
    |=> five_out[1] == $past(ctl[1].f5_sel ? gen[3] : gen[2]))
    else $error("five-input mux picked wrong generator");

  a_six_mux: assert property (six_sel
    |=> six_out == $past(ctl[1].f5_sel ? gen[3] : gen[2]))
    else $error("six-input mux picked wrong slice");

  a_feed_thru: assert property (1'b1 |=> feed_out == $past(feed_in))
    else $error("feedthrough path altered data");

  a_chain_pass: assert property (gen[0] && gen[1] |=> cout[0] == $past(ctl[0].cin))
    else $error("carry did not propagate through two bits");

  a_sum_xor: assert property (gen[2] |=> sum_out[2] == !$past(ctl[1].cin))
    else $error("adder sum bit wrong");

  a_and_gen: assert property (!gen[2] && !gen[3] && cfg[1].mult_and[1]
    |=> cout[1] == $past(ctl[1].addr[1][0] && ctl[1].addr[1][1]))
    else $error("partial product did not generate carry");

  a_bus_drive: assert property (1'b1
    |=> bus_oe == $past(drv_en) && bus_o == $past(drv_data))
    else $error("bus driver enable or data wrong");

  // The checks below pin each lookup mode to the slice that the scenarios put it in.
  a_pair_low: assert property (cfg[0].mode == lbt_pkg::LBT_RM_16X2 && act_edge[0] && ctl[0].we
    |=> s.lookup_function_gen[0][$past(ctl[0].addr[0])] == $past(ctl[0].bypass[0]))
    else $error("two-bit RAM lower bit not stored");

  a_pair_read: assert property (cfg[0].mode == lbt_pkg::LBT_RM_16X2
    |=> gen_out[1] == $past(s.lookup_function_gen[1][ctl[0].addr[0]]))
    else $error("two-bit RAM upper bit not read at shared address");

  a_ram_second: assert property (cfg[0].mode == lbt_pkg::LBT_RM_16X1 && act_edge[0] && ctl[0].we
    |=> s.lookup_function_gen[1][$past(ctl[0].addr[1])] == $past(ctl[0].bypass[1]))
    else $error("second single RAM write not stored");

  a_ram_follow: assert property (cfg[0].mode == lbt_pkg::LBT_RM_16X1
    |=> gen_out[1] == $past(s.lookup_function_gen[1][ctl[0].addr[1]]))
    else $error("RAM read did not follow its address");

  a_wide_low: assert property (cfg[1].mode == lbt_pkg::LBT_RM_32X1 && act_edge[1] && ctl[1].we
    && !ctl[1].f5_sel |=> s.lookup_function_gen[2][$past(ctl[1].addr[0])] == $past(ctl[1].bypass[0]))
    else $error("wide RAM lower half not written");

  a_wide_high: assert property (cfg[1].mode == lbt_pkg::LBT_RM_32X1 && act_edge[1] && ctl[1].we
    && ctl[1].f5_sel |=> s.lookup_function_gen[3][$past(ctl[1].addr[0])] == $past(ctl[1].bypass[0]))
    else $error("wide RAM upper half not written");

  a_wide_keep: assert property (cfg[1].mode == lbt_pkg::LBT_RM_32X1 && ctl[1].f5_sel
    |=> $stable(s.lookup_function_gen[2]))
    else $error("wide RAM lower half changed while upper selected");

  a_wide_keep_hi: assert property (cfg[1].mode == lbt_pkg::LBT_RM_32X1 && !ctl[1].f5_sel
    |=> $stable(s.lookup_function_gen[3]))
    else $error("wide RAM upper half changed while lower selected");

  a_wide_read: assert property (cfg[1].mode == lbt_pkg::LBT_RM_32X1
    |=> five_out[1] == $past(ctl[1].f5_sel ? s.lookup_function_gen[3][ctl[1].addr[0]] :
    s.lookup_function_gen[2][ctl[1].addr[0]]))
    else $error("wide RAM read picked wrong half");

  a_dual_mirror: assert property (cfg[0].mode == lbt_pkg::LBT_RM_DUAL && act_edge[0] && ctl[0].we
    |=> s.lookup_function_gen[1][$past(ctl[0].addr[0])] == $past(ctl[0].bypass[0]))
    else $error("dual-port copy not written");

  a_dual_read: assert property (cfg[0].mode == lbt_pkg::LBT_RM_DUAL
    |=> gen_out[1] == $past(s.lookup_function_gen[1][ctl[0].addr[1]]))
    else $error("dual-port read port used wrong address");

  a_logic_keep: assert property (cfg[1].mode == lbt_pkg::LBT_RM_LOGIC
    |=> $stable(s.lookup_function_gen[3:2]))
    else $error("logic lookup contents changed");

  a_logic_top: assert property (cfg[1].mode == lbt_pkg::LBT_RM_LOGIC
    |=> gen_out[3] == $past(s.lookup_function_gen[3][ctl[1].addr[1]]))
    else $error("top generator does not match lookup contents");

  a_shift_low: assert property (cfg[1].mode == lbt_pkg::LBT_RM_SHIFT && act_edge[1] && ctl[1].we
    |=> s.lookup_function_gen[2] == {$past(s.lookup_function_gen[2][`LBT_LUT_DEPTH-2:0]), $past(ctl[1].bypass[0])})
    else $error("lower shift register did not advance by one");

  a_shift_hold: assert property (cfg[1].mode == lbt_pkg::LBT_RM_SHIFT
    && !(act_edge[1] && ctl[1].we) |=> $stable(s.lookup_function_gen[3:2]))
    else $error("shift register moved without an enabled edge");

  a_ram_edge: assert property (cfg[0].mode != lbt_pkg::LBT_RM_LOGIC && !act_edge[0]
    |=> $stable(s.lookup_function_gen[1:0]))
    else $error("lookup contents changed without an active edge");

  a_sum_first: assert property (1'b1
    |=> sum_out[0] == ($past(gen[0]) ^ $past(ctl[0].cin)))
    else $error("first adder sum bit wrong");

  a_sum_second: assert property (1'b1
    |=> sum_out[1] == $past(gen[1] ^ (gen[0] ? ctl[0].cin : cgen[0])))
    else $error("second adder sum bit wrong");

  a_cascade_gen: assert property (!gen[0] && !gen[1] && !cfg[0].mult_and[1]
    |=> cout[0] == $past(ctl[0].bypass[1]))
    else $error("cascade did not take bypass as carry generate");

  a_chain_top: assert property (gen[2] && gen[3] |=> cout[1] == $past(ctl[1].cin))
    else $error("upper chain did not propagate");

  a_five_low: assert property (1'b1
    |=> five_out[0] == $past(ctl[0].f5_sel ? gen[1] : gen[0]))
    else $error("lower five-input mux picked wrong generator");

  a_six_low: assert property (!six_sel
    |=> six_out == $past(ctl[0].f5_sel ? gen[1] : gen[0]))
    else $error("six-input mux did not pick lower slice");

  a_bus_off: assert property (!drv_en[1] |=> !bus_oe[1])
    else $error("bus driver enabled without request");

  c_dual_write: cover property (cfg[0].mode == lbt_pkg::LBT_RM_DUAL && wr[1]);
  c_shift_run: cover property (cfg[1].mode == lbt_pkg::LBT_RM_SHIFT && sh[3]);
  c_ram32_write: cover property (cfg[1].mode == lbt_pkg::LBT_RM_32X1 && wr[3]);
  c_six_sel: cover property (six_sel && ctl[1].f5_sel);
endmodule
`default_nettype wire

/* File: sim/lbt_fabric_model.sv */
// Neighbouring fabric model: slice clock source and shared bus line.
`timescale 1ns/1ps
`default_nettype none
module lbt_fabric_model
(
  input wire logic clk,
  input wire logic [1:0] hold,
  input wire logic [1:0] bus_o,
  input wire logic [1:0] bus_oe,
  output logic [1:0] slice_clk,
  output logic [1:0] bus_line
);
  logic [1:0] last;
  initial slice_clk = 2'h0;
  initial last = 2'h0;
  // The slice clock stands still at 0 unless the bench asks for a high phase.
  always @(posedge clk)
  begin
    slice_clk <= hold;
    last <= bus_line;
  end
  // No keeper here: a released line flips, so a stale level is never taken for a drive.
  assign bus_line = (bus_o & bus_oe) | (~last & ~bus_oe);
endmodule
`default_nettype wire

/* File: sim/test_lbt_tile.sv */
// Self-checking bench for the logic block tile.
`timescale 1ns/1ps
`default_nettype none
module test_lbt_tile;
  logic clk, rst_n, six_sel, six_out;
  lbt_pkg::lbt_slice_cfg_s [1:0] cfg;
  lbt_pkg::lbt_slice_ctl_s [1:0] c;
  lbt_pkg::lbt_slice_ctl_s [1:0] ctl;
  logic [3:0] feed_in, gen_out, q, sum_out, feed_out;
  logic [1:0] drv_data, drv_en, hold, slice_clk, bus_line, five_out, cout, bus_o, bus_oe;
  logic [3:0][15:0] m;
  int error_cnt = 0;
  int num_checks = 0;

  always_comb
  begin
    ctl = c;
    ctl[0].clk_in = slice_clk[0];
    ctl[1].clk_in = slice_clk[1];
  end

  lbt_tile DUT
  (
    .clk(clk), .rst_n(rst_n), .cfg(cfg), .ctl(ctl), .six_sel(six_sel), .feed_in(feed_in),
    .drv_data(drv_data), .drv_en(drv_en), .gen_out(gen_out), .q(q), .sum_out(sum_out),
    .five_out(five_out), .six_out(six_out), .cout(cout), .feed_out(feed_out),
    .bus_o(bus_o), .bus_oe(bus_oe)
  );

  lbt_fabric_model fabric
  (
    .clk(clk), .hold(hold), .bus_o(bus_o), .bus_oe(bus_oe), .slice_clk(slice_clk),
    .bus_line(bus_line)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One high phase of both slice clocks, n cycles long; q has settled on return.
  task automatic pulse(input int n);
    @(posedge clk);
    hold <= 2'h3;
    repeat (n) @(posedge clk);
    hold <= 2'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic rst(input lbt_pkg::lbt_ram_mode_e m0, input lbt_pkg::lbt_ram_mode_e m1,
    input logic af);
    @(posedge clk);
    rst_n <= 1'b0;
    hold <= 2'h0;
    c <= '0;
    cfg[0].mode <= m0;
    cfg[1].mode <= m1;
    cfg[0].async_force <= af;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    m = {16'h00ff, 16'hfffe, 16'h8000, 16'h6996};
    @(posedge clk);
    #1;
    chk("q after reset", 4'h9, q);
  endtask

  task automatic wr(input logic [3:0] a0, input logic [3:0] a1, input logic [1:0] b0,
    input logic [1:0] b1, input logic f5);
    @(posedge clk);
    for (int i = 0; i < 2; i++)
    begin
      c[i].we <= 1'b1;
      c[i].addr <= {a1, a0};
      c[i].f5_sel <= f5;
    end
    c[0].bypass <= b0;
    c[1].bypass <= b1;
    pulse(1);
    @(posedge clk);
    c[0].we <= 1'b0;
    c[1].we <= 1'b0;
  endtask

  // Walks every lookup address; the bench's own content copy m predicts each generator, sum, carry and mux output.
  task automatic sweep();
    logic [3:0] eg, es;
    logic [1:0] ec, ef;
    logic ci;
    for (int a = 0; a < 16; a++)
    begin
      @(posedge clk);
      for (int i = 0; i < 2; i++)
      begin
        c[i].addr <= {2{a[3:0]}};
        c[i].cin <= a[2];
        c[i].bypass <= a[1:0];
        c[i].f5_sel <= a[0];
      end
      six_sel <= a[1];
      feed_in <= a[3:0];
      drv_data <= a[1:0];
      drv_en <= a[3:2];
      @(posedge clk);
      #1;
      for (int s = 0; s < 2; s++)
      begin
        ci = a[2];
        for (int k = 0; k < 2; k++)
        begin
          eg[2*s+k] = m[2*s+k][a];
          es[2*s+k] = eg[2*s+k] ^ ci;
          ci = eg[2*s+k] ? ci : (cfg[s].mult_and[k] ? a[0] & a[1] : a[k]);
        end
        ec[s] = ci;
        ef[s] = eg[2*s+a[0]];
      end
      chk("gen_out", eg, gen_out);
      chk("sum_out", es, sum_out);
      chk("cout", ec, cout);
      chk("five_out", ef, five_out);
      chk("six_out", ef[a[1]], six_out);
      chk("feed_out", a[3:0], feed_out);
      chk("bus", {a[3:2], a[1:0] & a[3:2]}, {bus_oe, bus_line & bus_oe});
    end
    $display("test done, %0d checks so far", num_checks);
  endtask

  initial
  begin
    rst_n = 1'b0;
    hold = 2'h0;
    c = '0;
    six_sel = 1'b0;
    feed_in = 4'h0;
    drv_data = 2'h0;
    drv_en = 2'h0;
    cfg = '0;
    cfg[0].lut_init = {16'h8000, 16'h6996};
    cfg[1].lut_init = {16'h00ff, 16'hfffe};
    cfg[0].init_val = 2'h1;
    cfg[1].init_val = 2'h2;
    cfg[0].d_bypass = 2'h1;
    cfg[1].d_bypass = 2'h3;
    cfg[0].inv_ce = 1'b1;
    cfg[1].latch = 1'b1;
    cfg[1].mult_and = 2'h3;
    rst(lbt_pkg::LBT_RM_LOGIC, lbt_pkg::LBT_RM_LOGIC, 1'b0);
    // Slice 0 keeps D from its edge; the latch in slice 1 follows D while its clock is high.
    @(posedge clk);
    hold <= 2'h3;
    c[0].bypass <= 2'h2;
    c[1].bypass <= 2'h2;
    c[1].ce <= 1'b1;
    repeat (2) @(posedge clk);
    c[1].bypass <= 2'h1;
    @(posedge clk);
    hold <= 2'h0;
    repeat (2) @(posedge clk);
    #1;
    chk("q flop and latch", 4'h4, q);
    @(posedge clk);
    c[0].ce <= 1'b1;
    c[1].ce <= 1'b0;
    c[0].bypass <= 2'h1;
    c[1].bypass <= 2'h2;
    pulse(1);
    chk("q enable off", 4'h4, q);
    @(posedge clk);
    c[0].init_force <= 1'b1;
    c[1].init_force <= 1'b1;
    pulse(1);
    chk("q init force", 4'h9, q);
    @(posedge clk);
    c[0].init_force <= 1'b0;
    c[1].init_force <= 1'b0;
    c[0].opposite_force <= 1'b1;
    c[1].opposite_force <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("q sync force idle", 4'h9, q);
    pulse(1);
    chk("q opposite force", 4'h6, q);
    $display("storage test done, %0d checks so far", num_checks);
    wr(4'h3, 4'h5, 2'h3, 2'h3, 1'b0);
    sweep();
    rst(lbt_pkg::LBT_RM_16X1, lbt_pkg::LBT_RM_SHIFT, 1'b0);
    wr(4'h3, 4'h5, 2'h3, 2'h3, 1'b0);
    m[0][3] = 1'b1;
    m[1][5] = 1'b1;
    m[2] = {m[2][14:0], 1'b1};
    m[3] = {m[3][14:0], 1'b1};
    sweep();
    rst(lbt_pkg::LBT_RM_16X2, lbt_pkg::LBT_RM_32X1, 1'b0);
    wr(4'h4, 4'h9, 2'h2, 2'h1, 1'b1);
    m[0][4] = 1'b0;
    m[1][4] = 1'b1;
    m[3][4] = 1'b1;
    sweep();
    rst(lbt_pkg::LBT_RM_DUAL, lbt_pkg::LBT_RM_LOGIC, 1'b1);
    @(posedge clk);
    c[0].opposite_force <= 1'b1;
    c[1].opposite_force <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("q async force", 4'ha, q);
    wr(4'h0, 4'h7, 2'h1, 2'h3, 1'b0);
    m[0][0] = 1'b1;
    m[1][0] = 1'b1;
    @(posedge clk);
    c[0].addr <= {4'h0, 4'h3};
    repeat (2) @(posedge clk);
    #1;
    chk("dual read port", 2'h2, gen_out[1:0]);
    sweep();
    stop_test();
  end

  // The whole run takes well under 400 cycles.
  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
